// file: verilog/acs_ctrl_regs.sv
`timescale 1ns/1ps
module acs_ctrl_regs
	import acs_pkg::*;
#(
	parameter logic [6:0] DEV_ADDR = 7'h2a,
	// arbitrary revision value
	parameter logic [7:0] REV_ID = 8'h5a
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rstn,
	// two-wire control pins
	input wire logic sclIn,
	input wire logic sdaIn,
	output logic sdaOut,
	output logic sdaOe,
	// audio clocks
	input wire logic audioMclk,
	input wire logic bitClk,
	input wire logic frameClk,
	// fault sources
	input wire logic pllUnlock,
	input wire logic clipDetect,
	input wire logic protFault,
	// volume ramp length in steps
	input wire logic [11:0] volSlewSteps,
	// control outputs
	output logic dcBlockEn,
	output logic hardUnmute,
	output logic [1:0] deemphSel,
	output logic [3:0] fmtSel,
	output logic muteActive,
	output logic [11:0] recoverLevel
);
	acs_link_if lkIf ();

	acs_link_meter uMeter (
		.bitClk(bitClk),
		.rstn(rstn),
		.frameClk(frameClk),
		.lk(lkIf.link)
	);

	// ********************
	// synchronisers
	// ********************
	logic fMeta, fSync, fLast, bMeta, bSync, bLast;
	logic aMeta, aSync, aLast, cMeta, cSync, cLast, dMeta, dSync, dLast;
	logic frameEvt, bErrEvt, amRise;

	always_ff @(posedge mclk) begin
		fMeta <= lkIf.frameTgl;
		fSync <= fMeta;
		fLast <= fSync;
		bMeta <= lkIf.bitErrTgl;
		bSync <= bMeta;
		bLast <= bSync;
		aMeta <= audioMclk;
		aSync <= aMeta;
		aLast <= aSync;
		cMeta <= sclIn;
		cSync <= cMeta;
		cLast <= cSync;
		dMeta <= sdaIn;
		dSync <= dMeta;
		dLast <= dSync;
	end

	assign frameEvt = fSync ^ fLast;
	assign bErrEvt = bSync ^ bLast;
	assign amRise = aSync && !aLast;

	// ********************
	// clock measurement
	// ********************
	function automatic logic [2:0] ratioOf(input logic [11:0] n);
		if (n < RB_96) return RATIO_64;
		else if (n < RB_160) return RATIO_128;
		else if (n < RB_224) return RATIO_192;
		else if (n < RB_320) return RATIO_256;
		else if (n < RB_448) return RATIO_384;
		else if (n < RB_640) return RATIO_512;
		else return RATIO_RSV;
	endfunction

	function automatic logic [2:0] rateOf(input logic [15:0] p);
		if (p < PER_40K) return RATE_48;
		else if (p < PER_27K) return RATE_32;
		else if (p < PER_19K) return RATE_24;
		else if (p < PER_13K) return RATE_16;
		else if (p < PER_9K) return RATE_12;
		else return RATE_8;
	endfunction

	logic [15:0] perCnt, periodReg, syncCnt, perDiff;
	logic [11:0] mcCnt;
	logic [2:0] ratioReg, rateReg;
	logic seenReg, perValid;
	logic mclkErr, frmErr, slipErr, clkErrAny;

	assign perDiff = (perCnt > periodReg) ? perCnt - periodReg : periodReg - perCnt;
	assign mclkErr = frameEvt && perValid && ratioOf(mcCnt) != ratioReg;
	assign frmErr = frameEvt && perValid && perDiff > FRAME_TOL;
	// slip is a small phase error that a period check alone would not see
	assign slipErr = frameEvt && perValid && !frmErr && syncCnt > SLIP_TOL &&
		syncCnt < periodReg - SLIP_TOL;
	assign clkErrAny = mclkErr || frmErr || slipErr || bErrEvt;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			perCnt <= '0;
			mcCnt <= '0;
			periodReg <= '0;
			ratioReg <= RATIO_64;
			rateReg <= RATE_32;
			seenReg <= 1'b0;
			perValid <= 1'b0;
		end else if (frameEvt) begin
			perCnt <= 16'h0001;
			mcCnt <= amRise ? 12'h001 : 12'h000;
			seenReg <= 1'b1;
			if (seenReg) begin
				periodReg <= perCnt;
				ratioReg <= ratioOf(mcCnt);
				rateReg <= rateOf(perCnt);
				perValid <= 1'b1;
			end
		end else begin
			if (perCnt != 16'hffff)
				perCnt <= perCnt + 16'h0001;
			if (amRise && mcCnt != 12'hfff)
				mcCnt <= mcCnt + 12'h001;
		end
	end

	// internal frame sync free-runs at the measured period
	always_ff @(posedge mclk) begin
		if (!rstn)
			syncCnt <= '0;
		else if (frameEvt && (!perValid || slipErr || frmErr))
			syncCnt <= '0;
		else if (syncCnt >= periodReg - 16'h0001)
			syncCnt <= '0;
		else
			syncCnt <= syncCnt + 16'h0001;
	end

	// ********************
	// control bus slave
	// ********************
	acs_bus_e stReg;
	logic [3:0] bitCnt;
	logic [7:0] shReg, subReg, wrAddr, wrData;
	logic gotSub, rwBit, ackSeen, wrStb, sdaOeReg;
	logic sclRise, sclFall, startCond, stopCond;
	logic [7:0] errReg, sys1Reg, rdData;
	logic [3:0] fmtReg;

	assign sclRise = cSync && !cLast;
	assign sclFall = !cSync && cLast;
	assign startCond = cSync && cLast && dLast && !dSync;
	assign stopCond = cSync && cLast && !dLast && dSync;

	always_comb begin
		unique case (subReg)
			SUB_CLK: rdData = {rateReg, ratioReg, 2'b00};
			SUB_ID: rdData = REV_ID;
			SUB_ERR: rdData = errReg;
			SUB_SYS1: rdData = sys1Reg;
			SUB_FMT: rdData = {4'h0, fmtReg};
			default: rdData = 8'h00;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			stReg <= ST_IDLE;
			bitCnt <= '0;
			shReg <= '0;
			subReg <= '0;
			wrAddr <= '0;
			wrData <= '0;
			gotSub <= 1'b0;
			rwBit <= 1'b0;
			ackSeen <= 1'b0;
			wrStb <= 1'b0;
			sdaOeReg <= 1'b0;
		end else begin
			wrStb <= 1'b0;
			if (startCond) begin
				stReg <= ST_ADDR;
				bitCnt <= '0;
				sdaOeReg <= 1'b0;
			end else if (stopCond) begin
				stReg <= ST_IDLE;
				sdaOeReg <= 1'b0;
			end else begin
				unique case (stReg)
					ST_IDLE: begin
						sdaOeReg <= 1'b0;
					end
					ST_ADDR, ST_WDATA: begin
						if (sclRise) begin
							shReg <= {shReg[6:0], dSync};
							bitCnt <= bitCnt + 4'h1;
						end else if (sclFall && bitCnt == 4'h8) begin
							bitCnt <= '0;
							if (stReg == ST_ADDR) begin
								rwBit <= shReg[0];
								stReg <= (shReg[7:1] == DEV_ADDR) ? ST_ACKA : ST_IDLE;
								sdaOeReg <= (shReg[7:1] == DEV_ADDR);
							end else begin
								stReg <= ST_ACKW;
								sdaOeReg <= 1'b1;
								if (!gotSub) begin
									subReg <= shReg;
									gotSub <= 1'b1;
								end else begin
									wrStb <= 1'b1;
									wrAddr <= subReg;
									wrData <= shReg;
									subReg <= subReg + 8'h01;
								end
							end
						end
					end
					ST_ACKA: begin
						if (sclFall) begin
							if (rwBit) begin
								stReg <= ST_RDATA;
								shReg <= rdData;
								sdaOeReg <= !rdData[7];
							end else begin
								stReg <= ST_WDATA;
								gotSub <= 1'b0;
								sdaOeReg <= 1'b0;
							end
						end
					end
					ST_ACKW: begin
						if (sclFall) begin
							stReg <= ST_WDATA;
							sdaOeReg <= 1'b0;
						end
					end
					ST_RDATA: begin
						if (sclRise)
							bitCnt <= bitCnt + 4'h1;
						else if (sclFall && bitCnt == 4'h8) begin
							stReg <= ST_RACK;
							bitCnt <= '0;
							ackSeen <= 1'b0;
							sdaOeReg <= 1'b0;
							subReg <= subReg + 8'h01;
						end else if (sclFall) begin
							shReg <= {shReg[6:0], 1'b0};
							sdaOeReg <= !shReg[6];
						end
					end
					ST_RACK: begin
						if (sclRise) begin
							ackSeen <= !dSync;
							if (dSync)
								stReg <= ST_IDLE;
						end else if (sclFall && ackSeen) begin
							stReg <= ST_RDATA;
							shReg <= rdData;
							sdaOeReg <= !rdData[7];
						end
					end
					default: stReg <= ST_IDLE;
				endcase
			end
		end
	end

	// ********************
	// registers
	// ********************
	logic errWr;
	logic [7:0] errSet;

	assign errWr = wrStb && wrAddr == SUB_ERR;
	assign errSet = {mclkErr, pllUnlock, bErrEvt, frmErr, slipErr, clipDetect, protFault, 1'b0};

	// a new event in the clearing cycle survives the clear
	always_ff @(posedge mclk) begin
		if (!rstn)
			errReg <= 8'h00;
		else
			errReg <= ((errReg & (errWr ? wrData : 8'hff)) | errSet) & ERR_USED;
	end

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			sys1Reg <= SYS1_RESET;
			fmtReg <= FMT_RESET;
		end else if (wrStb && wrAddr == SUB_SYS1) begin
			sys1Reg <= wrData & SYS1_USED;
		end else if (wrStb && wrAddr == SUB_FMT) begin
			fmtReg <= wrData[3:0];
		end
	end

	// ********************
	// outputs and unmute recovery
	// ********************
	logic [2:0] goodCnt;

	always_ff @(posedge mclk) begin
		if (!rstn) begin
			dcBlockEn <= 1'b1;
			hardUnmute <= 1'b0;
			deemphSel <= DEEMPH_NONE;
			fmtSel <= FMT_RESET;
			sdaOut <= 1'b0;
			sdaOe <= 1'b0;
		end else begin
			dcBlockEn <= sys1Reg[SYS_DCB];
			hardUnmute <= sys1Reg[SYS_HARD];
			deemphSel <= sys1Reg[1:0];
			fmtSel <= fmtReg;
			sdaOut <= 1'b0;
			sdaOe <= sdaOeReg;
		end
	end

	// muted until a few clean frames follow the last clock error
	always_ff @(posedge mclk) begin
		if (!rstn) begin
			muteActive <= 1'b1;
			goodCnt <= '0;
			recoverLevel <= '0;
		end else if (clkErrAny) begin
			muteActive <= 1'b1;
			goodCnt <= '0;
			recoverLevel <= '0;
		end else if (frameEvt) begin
			if (muteActive) begin
				goodCnt <= goodCnt + 3'h1;
				if (goodCnt == STABLE_FRAMES - 3'h1) begin
					muteActive <= 1'b0;
					recoverLevel <= sys1Reg[SYS_HARD] ? volSlewSteps : 12'h000;
				end
			end else if (recoverLevel < volSlewSteps) begin
				recoverLevel <= sys1Reg[SYS_HARD] ? volSlewSteps : recoverLevel + 12'h001;
			end
		end
	end

	// ********************
	// checks
	// ********************
	AST_RATIO_384: assert property (@(posedge mclk) disable iff (!rstn)
		(frameEvt && seenReg && mcCnt >= RB_320 && mcCnt < RB_448) |=> ratioReg == RATIO_384)
		else $error("ratio code for 384 wrong");
	AST_ID_READ: assert property (@(posedge mclk) disable iff (!rstn)
		(stReg == ST_ACKA && sclFall && rwBit && subReg == SUB_ID && !startCond && !stopCond)
		|=> shReg == REV_ID)
		else $error("identifier read wrong");
	AST_ERR_STICKY: assert property (@(posedge mclk) disable iff (!rstn)
		!errWr |=> (errReg & $past(errReg)) == $past(errReg))
		else $error("error flag cleared by hardware");
	AST_MCLK_ERR: assert property (@(posedge mclk) disable iff (!rstn)
		mclkErr |=> errReg[ERR_MCLK] ##1 (errReg[ERR_MCLK] || $past(errWr)))
		else $error("ratio change not flagged");
	AST_BCK_ERR: assert property (@(posedge mclk) disable iff (!rstn)
		$changed(bSync) |=> errReg[ERR_BCK])
		else $error("bit count error not flagged");
	AST_FRM_ERR: assert property (@(posedge mclk) disable iff (!rstn)
		(frameEvt && perValid && perDiff > FRAME_TOL) |=> errReg[ERR_FRM] && muteActive)
		else $error("frame change not flagged");
	AST_SLIP: assert property (@(posedge mclk) disable iff (!rstn)
		slipErr |=> errReg[ERR_SLIP] && syncCnt == 16'h0000)
		else $error("slip not flagged");
	AST_FAULTS: assert property (@(posedge mclk) disable iff (!rstn)
		(pllUnlock && clipDetect && protFault) |=> errReg[ERR_PLL] && errReg[ERR_CLIP] &&
		errReg[ERR_PROT])
		else $error("fault flags not set");
	AST_SOFT_RAMP: assert property (@(posedge mclk) disable iff (!rstn)
		(frameEvt && !clkErrAny && !muteActive && !sys1Reg[SYS_HARD] &&
		recoverLevel < volSlewSteps) |=> recoverLevel == $past(recoverLevel) + 12'h001)
		else $error("soft unmute step wrong");
	AST_HARD_UNMUTE: assert property (@(posedge mclk) disable iff (!rstn)
		(frameEvt && !clkErrAny && muteActive && goodCnt == STABLE_FRAMES - 3'h1 &&
		sys1Reg[SYS_HARD]) |=> !muteActive && recoverLevel == $past(volSlewSteps))
		else $error("hard unmute not single step");
	AST_RESET_DEFAULTS: assert property (@(posedge mclk) disable iff (!rstn)
		$rose(rstn) |-> sys1Reg == SYS1_RESET && fmtReg == FMT_RESET ##1 fmtSel == FMT_RESET)
		else $error("reset defaults wrong");

endmodule // acs_ctrl_regs

// file: verilog/acs_pkg.sv
package acs_pkg;

	// ********************
	// timing
	// ********************
	localparam int CLK_HZ = 250_000_000;
	localparam int CLK_NS = 4;
	localparam int FRAME_TOL_NS = 64;
	localparam int SLIP_TOL_NS = 32;
	localparam logic [15:0] FRAME_TOL = 16'(FRAME_TOL_NS / CLK_NS);
	localparam logic [15:0] SLIP_TOL = 16'(SLIP_TOL_NS / CLK_NS);
	localparam logic [2:0] STABLE_FRAMES = 3'h4;

	// ********************
	// subaddresses
	// ********************
	localparam logic [7:0] SUB_CLK = 8'h00;
	localparam logic [7:0] SUB_ID = 8'h01;
	localparam logic [7:0] SUB_ERR = 8'h02;
	localparam logic [7:0] SUB_SYS1 = 8'h03;
	localparam logic [7:0] SUB_FMT = 8'h04;

	// ********************
	// fields and reset values
	// ********************
	localparam int ERR_MCLK = 7;
	localparam int ERR_PLL = 6;
	localparam int ERR_BCK = 5;
	localparam int ERR_FRM = 4;
	localparam int ERR_SLIP = 3;
	localparam int ERR_CLIP = 2;
	localparam int ERR_PROT = 1;
	localparam logic [7:0] ERR_USED = 8'hfe;
	localparam int SYS_DCB = 7;
	localparam int SYS_HARD = 5;
	localparam logic [7:0] SYS1_RESET = 8'h80;
	localparam logic [7:0] SYS1_USED = 8'ha3;
	localparam logic [1:0] DEEMPH_NONE = 2'h0;
	localparam logic [1:0] DEEMPH_32K = 2'h1;
	localparam logic [1:0] DEEMPH_44K = 2'h2;
	localparam logic [1:0] DEEMPH_48K = 2'h3;
	localparam logic [3:0] FMT_RESET = 4'h5;

	// ********************
	// clock ratio and rate codes
	// ********************
	localparam logic [2:0] RATIO_64 = 3'h0;
	localparam logic [2:0] RATIO_128 = 3'h1;
	localparam logic [2:0] RATIO_192 = 3'h2;
	localparam logic [2:0] RATIO_256 = 3'h3;
	localparam logic [2:0] RATIO_384 = 3'h4;
	localparam logic [2:0] RATIO_512 = 3'h5;
	localparam logic [2:0] RATIO_RSV = 3'h6;
	localparam logic [11:0] RB_96 = 12'h060;
	localparam logic [11:0] RB_160 = 12'h0a0;
	localparam logic [11:0] RB_224 = 12'h0e0;
	localparam logic [11:0] RB_320 = 12'h140;
	localparam logic [11:0] RB_448 = 12'h1c0;
	localparam logic [11:0] RB_640 = 12'h280;
	localparam logic [2:0] RATE_48 = 3'h3;
	localparam logic [2:0] RATE_32 = 3'h0;
	localparam logic [2:0] RATE_24 = 3'h5;
	localparam logic [2:0] RATE_16 = 3'h4;
	localparam logic [2:0] RATE_12 = 3'h7;
	localparam logic [2:0] RATE_8 = 3'h6;
	localparam logic [15:0] PER_40K = 16'(CLK_HZ / 40000);
	localparam logic [15:0] PER_27K = 16'(CLK_HZ / 27000);
	localparam logic [15:0] PER_19K = 16'(CLK_HZ / 19000);
	localparam logic [15:0] PER_13K = 16'(CLK_HZ / 13500);
	localparam logic [15:0] PER_9K = 16'(CLK_HZ / 9500);
	localparam int BCNT_W = 9;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ADDR = 3'b001,
		ST_ACKA = 3'b011,
		ST_WDATA = 3'b010,
		ST_ACKW = 3'b110,
		ST_RDATA = 3'b111,
		ST_RACK = 3'b101
	} acs_bus_e;

endpackage

// file: verilog/acs_link_if.sv
`timescale 1ns/1ps
interface acs_link_if;
	logic frameTgl;
	logic bitErrTgl;
	modport link (output frameTgl, output bitErrTgl);
	modport core (input frameTgl, input bitErrTgl);
endinterface

// file: verilog/acs_link_meter.sv
`timescale 1ns/1ps
module acs_link_meter
	import acs_pkg::*;
(
	// link clock and reset
	input wire logic bitClk,
	input wire logic rstn,
	// frame clock pin
	input wire logic frameClk,
	// events to core
	acs_link_if.link lk
);
	logic rstMeta, rstnLink;
	logic frmMeta, frmSync, frmLast;
	logic [BCNT_W-1:0] cntReg, prevReg;
	logic seenReg, validReg;
	logic frameRise;

	// reset released into the link domain; it only acts while the link clock runs
	always_ff @(posedge bitClk) begin
		rstMeta <= rstn;
		rstnLink <= rstMeta;
	end

	always_ff @(posedge bitClk) begin
		frmMeta <= frameClk;
		frmSync <= frmMeta;
		frmLast <= frmSync;
	end

	assign frameRise = frmSync && !frmLast;

	always_ff @(posedge bitClk) begin
		if (!rstnLink) begin
			cntReg <= '0;
			prevReg <= '0;
			seenReg <= 1'b0;
			validReg <= 1'b0;
			lk.frameTgl <= 1'b0;
			lk.bitErrTgl <= 1'b0;
		end else if (frameRise) begin
			cntReg <= BCNT_W'(1);
			seenReg <= 1'b1;
			lk.frameTgl <= !lk.frameTgl;
			if (seenReg) begin
				prevReg <= cntReg;
				validReg <= 1'b1;
				if (validReg && cntReg != prevReg)
					lk.bitErrTgl <= !lk.bitErrTgl;
			end
		end else begin
			cntReg <= cntReg + BCNT_W'(1);
		end
	end

	AST_BCK_TOGGLE: assert property (@(posedge bitClk) disable iff (!rstnLink)
		(frameRise && seenReg && validReg && cntReg != prevReg) |=> $changed(lk.bitErrTgl))
		else $error("bit count change not signalled");

endmodule // acs_link_meter

// file: sim/acs_audio_src.sv
`timescale 1ns/1ps
// ********************
// audio source: free-running bit, frame and master clocks
// ********************
module acs_audio_src (
	// clocks towards the receiver
	output logic bitClk,
	output logic frameClk,
	output logic audioMclk,
	// frame length in bit clocks, master clock half period in ns
	input wire logic [8:0] bitsPerFrame,
	input wire logic [7:0] mclkHalf
);
	logic [8:0] bitCnt;

	// odd start offset keeps the link clock unrelated in phase to the core clock
	initial begin
		bitClk = 1'b0;
		#7;
		forever #24 bitClk = ~bitClk;
	end

	initial begin
		audioMclk = 1'b0;
		forever #(mclkHalf) audioMclk = ~audioMclk;
	end

	initial begin
		bitCnt = 9'h000;
		frameClk = 1'b0;
	end

	// frame clock moves on the falling bit edge so the receiver samples it settled
	always @(negedge bitClk) begin
		bitCnt <= (bitCnt >= bitsPerFrame - 9'h001) ? 9'h000 : bitCnt + 9'h001;
		frameClk <= (bitCnt < (bitsPerFrame >> 1));
	end
endmodule // acs_audio_src

// file: sim/tb_audio_clock_status_control_regs.sv
`timescale 1ns/1ps
module tb_audio_clock_status_control_regs import acs_pkg::*;;
	// bus half period: 40 ns
	localparam int Q = 10;
	logic mclk = 1'b0;
	logic rstn = 1'b0;
	logic sclIn = 1'b1;
	logic sdaHost = 1'b1;
	logic sdaIn;
	logic sdaOut;
	logic sdaOe;
	logic bitClk;
	logic frameClk;
	logic audioMclk;
	logic pllUnlock = 1'b0;
	logic clipDetect = 1'b0;
	logic protFault = 1'b0;
	logic [11:0] volSlewSteps = 12'h003;
	logic [8:0] bitsPerFrame = 9'h0c0;
	logic [7:0] mclkHalf = 8'h0c;
	logic dcBlockEn;
	logic hardUnmute;
	logic muteActive;
	logic [1:0] deemphSel;
	logic [3:0] fmtSel;
	logic [11:0] recoverLevel;
	logic [7:0] rd;
	int errCount = 0;
	int compares = 0;

	// open-drain data line with pull-up
	assign sdaIn = sdaHost & ~sdaOe;
	always #2 mclk = ~mclk;

	acs_audio_src src (.bitClk(bitClk), .frameClk(frameClk), .audioMclk(audioMclk),
		.bitsPerFrame(bitsPerFrame), .mclkHalf(mclkHalf));

	// arbitrary revision value
	acs_ctrl_regs #(.REV_ID(8'h3c)) dut (.mclk(mclk), .rstn(rstn), .sclIn(sclIn),
		.sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe), .audioMclk(audioMclk),
		.bitClk(bitClk), .frameClk(frameClk), .pllUnlock(pllUnlock),
		.clipDetect(clipDetect), .protFault(protFault), .volSlewSteps(volSlewSteps),
		.dcBlockEn(dcBlockEn), .hardUnmute(hardUnmute), .deemphSel(deemphSel),
		.fmtSel(fmtSel), .muteActive(muteActive), .recoverLevel(recoverLevel));

	// ********************
	// common tasks
	// ********************
	task automatic hw(input int n);
		repeat (n) @(posedge mclk);
	endtask

	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		compares++;
		if (got !== exp) begin
			errCount++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic results();
		if (errCount == 0 && compares > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask

	task automatic waitOn(input bit useMute, input logic v);
		logic s;
		for (int i = 0; i < 40000; i++) begin
			s = useMute ? muteActive : frameClk;
			if (s === v) break;
			@(posedge mclk);
		end
		if (s !== v) begin
			errCount++;
			$display("mismatch at %0t: wait timed out", $time);
			results();
		end
	endtask

	task automatic waitFr(input int n);
		repeat (n) begin
			waitOn(1'b0, 1'b0);
			waitOn(1'b0, 1'b1);
		end
	endtask

	// ********************
	// two-wire control bus
	// ********************
	task automatic bitx(input logic b, output logic r);
		sdaHost <= b;
		hw(Q);
		sclIn <= 1'b1;
		hw(Q / 2);
		r = sdaIn;
		hw(Q / 2);
		sclIn <= 1'b0;
		hw(2);
	endtask

	task automatic startC();
		sdaHost <= 1'b1;
		hw(Q);
		sclIn <= 1'b1;
		hw(Q);
		sdaHost <= 1'b0;
		hw(Q);
		sclIn <= 1'b0;
		hw(2);
	endtask

	task automatic stopC();
		sdaHost <= 1'b0;
		hw(Q);
		sclIn <= 1'b1;
		hw(Q);
		sdaHost <= 1'b1;
		hw(Q);
	endtask

	task automatic wbyte(input logic [7:0] d);
		logic r;
		for (int i = 7; i >= 0; i--) bitx(d[i], r);
		bitx(1'b1, r);
	endtask

	task automatic regWr(input logic [7:0] sub, input logic [7:0] v);
		startC();
		wbyte(8'h54);
		wbyte(sub);
		wbyte(v);
		stopC();
	endtask

	task automatic regRd(input logic [7:0] sub, output logic [7:0] v);
		logic r;
		startC();
		wbyte(8'h54);
		wbyte(sub);
		startC();
		wbyte(8'h55);
		for (int i = 7; i >= 0; i--) begin
			bitx(1'b1, r);
			v[i] = r;
		end
		// not-acknowledge ends the read
		bitx(1'b1, r);
		stopC();
	endtask

	// ********************
	// scenarios
	// ********************
	task automatic tReset();
		chk(dcBlockEn, 1'b1);
		chk(deemphSel, DEEMPH_NONE);
		chk(fmtSel, FMT_RESET);
		regRd(SUB_SYS1, rd);
		chk(rd, SYS1_RESET);
		regRd(SUB_FMT, rd);
		chk(rd, FMT_RESET);
		regWr(SUB_ID, 8'h00);
		regRd(SUB_ID, rd);
		chk(rd, 8'h3c);
		regRd(8'h20, rd);
		chk(rd, 8'h00);
	endtask

	task automatic tDetect();
		waitOn(1'b1, 1'b0);
		@(posedge mclk);
		chk(recoverLevel < volSlewSteps, 1'b1);
		waitFr(4);
		chk(recoverLevel, volSlewSteps);
		regRd(SUB_CLK, rd);
		chk(rd, {RATE_48, RATIO_384, 2'b00});
		regWr(SUB_ERR, 8'h00);
		regRd(SUB_ERR, rd);
		chk(rd, 8'h00);
	endtask

	task automatic tSys1();
		logic [7:0] v[4] = '{8'h00, 8'h21, 8'ha2, 8'h83};
		for (int i = 0; i < 4; i++) begin
			regWr(SUB_SYS1, v[i]);
			regRd(SUB_SYS1, rd);
			chk(rd, v[i]);
			chk(deemphSel, v[i][1:0]);
			chk(dcBlockEn, v[i][SYS_DCB]);
			chk(hardUnmute, v[i][SYS_HARD]);
		end
		regWr(SUB_SYS1, 8'hff);
		regRd(SUB_SYS1, rd);
		chk(rd, SYS1_USED);
		regWr(SUB_FMT, 8'h08);
		chk(fmtSel, 4'h8);
	endtask

	// hard unmute stays selected from here on
	task automatic tBits();
		bitsPerFrame <= 9'h0be;
		waitFr(2);
		bitsPerFrame <= 9'h0c0;
		waitFr(1);
		chk(muteActive, 1'b1);
		waitOn(1'b1, 1'b0);
		@(posedge mclk);
		chk(recoverLevel, volSlewSteps);
		regRd(SUB_ERR, rd);
		chk(rd & 8'h30, 8'h30);
		regWr(SUB_ERR, 8'h00);
		regRd(SUB_ERR, rd);
		chk(rd, 8'h00);
	endtask

	task automatic tMclk();
		mclkHalf <= 8'h09;
		waitFr(4);
		regRd(SUB_CLK, rd);
		chk(rd[4:2], RATIO_512);
		regRd(SUB_ERR, rd);
		chk(rd[ERR_MCLK], 1'b1);
	endtask

	task automatic tFaults();
		regWr(SUB_ERR, 8'h00);
		pllUnlock <= 1'b1;
		clipDetect <= 1'b1;
		protFault <= 1'b1;
		hw(1);
		pllUnlock <= 1'b0;
		clipDetect <= 1'b0;
		protFault <= 1'b0;
		regRd(SUB_ERR, rd);
		chk(rd & 8'h46, 8'h46);
		regWr(SUB_ERR, 8'hfb);
		regRd(SUB_ERR, rd);
		chk(rd & 8'h46, 8'h42);
		regWr(SUB_ERR, 8'h00);
		regRd(SUB_ERR, rd);
		chk(rd, 8'h00);
	endtask

	// reset is held long enough for the link domain to see several bit clocks
	initial begin
		hw(40);
		rstn <= 1'b1;
		hw(4);
		tReset();
		tDetect();
		tSys1();
		tBits();
		tMclk();
		tFaults();
		results();
	end
endmodule // tb_audio_clock_status_control_regs
